// ===== tow_defs.svh
// Purpose: Offsets, field positions, reset values and clock source codes for the overflow/wake block
// Assumes: Byte-wide register port, one register per address
// Notes:   Definitions only
`ifndef TOW_DEFS_SVH
`define TOW_DEFS_SVH

// Register addresses
`define TOW_ADDR_W          3
`define TOW_OFF_COUNT_LO    3'h0
`define TOW_OFF_COUNT_HI    3'h1
`define TOW_OFF_CTRL        3'h2
`define TOW_OFF_REQ1        3'h3
`define TOW_OFF_EN1         3'h4
`define TOW_OFF_INTERRUPT_CONTROL_REG      3'h5
`define TOW_OFF_EN3         3'h6
`define TOW_OFF_STATE       3'h7

// Field positions
`define TOW_CTRL_ON_BIT     0
`define TOW_CTRL_SYNC_BIT   2
`define TOW_CTRL_OSC_BIT    3
`define TOW_CTRL_CS_LO      4
`define TOW_CTRL_CS_HI      5
`define TOW_REQ1_OVF_BIT    0
`define TOW_EN1_OVF_BIT     0
`define TOW_INTERRUPT_CONTROL_REG_PERIPHERAL_IRQ_ENABLE_BIT 6
`define TOW_INTERRUPT_CONTROL_REG_GIE_BIT  7

// Reset values
`define TOW_RST_COUNT       16'h0000
`define TOW_RST_BYTE        8'h00
`define TOW_COUNT_MAX       16'hFFFF

// Clock source codes
`define TOW_CS_SYS          2'h0
`define TOW_CS_EXT          2'h1
`define TOW_CS_OSC          2'h2
`define TOW_CS_EXT_ALT      2'h3

`endif

// ===== tow_pkg.sv
// Purpose: Types shared by the overflow/wake block
// Assumes: Constants come from tow_defs.svh
// Notes:   No imports anywhere; use tow_pkg::name
package tow_pkg;

  // Counter control fields
  typedef struct packed {
    logic [1:0] cs;
    logic       osc_en;
    logic       sync;
    logic       on;
  } tow_ctrl_t;

  // Global enables
  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_irq_enable;
  } tow_glob_t;

  // Core power state, one-hot
  typedef enum logic [2:0] {
    TOW_ST_RUN   = 3'b001,
    TOW_ST_SLEEP = 3'b010,
    TOW_ST_WAKE  = 3'b100
  } tow_state_t;

endpackage

// ===== tow_tick_sel.sv
// Purpose: Picks the count source and produces a one-cycle count tick
// Assumes: External pins are synchronous to mclk
// Notes:   Rising edges of the selected pin count
`include "tow_defs.svh"
`timescale 1ns/100ps
module tow_tick_sel (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire tow_pkg::tow_ctrl_t ctrl,
  input  wire logic              sleeping,
  input  wire logic              ext_clk_in,
  input  wire logic              sec_osc_in,
  output logic                   tick
);

  logic ext_q;
  logic osc_q;
  logic ext_rise;
  logic osc_rise;
  logic src_tick;

  // Previous pin levels for edge detection
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ext_q <= 1'b0;
      osc_q <= 1'b0;
    end else begin
      ext_q <= ext_clk_in;
      osc_q <= sec_osc_in;
    end
  end

  assign ext_rise = ext_clk_in & ~ext_q;
  assign osc_rise = sec_osc_in & ~osc_q & ctrl.osc_en;

  // Source select; system clock is dead in sleep
  always_comb begin
    unique case (ctrl.cs)
      `TOW_CS_SYS:     src_tick = ~sleeping;
      `TOW_CS_EXT:     src_tick = ext_rise;
      `TOW_CS_OSC:     src_tick = osc_rise;
      `TOW_CS_EXT_ALT: src_tick = ext_rise;
    endcase
  end

  // Sleep counting only when asynchronous
  assign tick = ctrl.on & src_tick & (~sleeping | ctrl.sync);

endmodule

// ===== tow_irq_gate.sv
// Purpose: Enable gating for the overflow and bank-3 interrupt requests
// Assumes: Flags and enables are register outputs
// Notes:   Purely combinational
`timescale 1ns/100ps
module tow_irq_gate (
  input  wire logic               ovf_flag,
  input  wire logic               ovf_ie,
  input  wire tow_pkg::tow_ctrl_t ctrl,
  input  wire tow_pkg::tow_glob_t glob,
  input  wire logic [7:0]         req3,
  input  wire logic [7:0]         en3,
  output logic                    periph_pend,
  output logic                    irq,
  output logic                    wake_arm
);

  logic ovf_pend;

  // Overflow request needs counter on and its own enable
  assign ovf_pend    = ovf_flag & ovf_ie & ctrl.on;
  // Every peripheral source blocked without the peripheral enable
  assign periph_pend = glob.peripheral_irq_enable & (ovf_pend | (|(req3 & en3)));
  assign irq         = glob.global_irq_enable & periph_pend;
  // Wake-up armed without the global enable
  assign wake_arm    = glob.peripheral_irq_enable & ovf_ie & ctrl.on & ctrl.sync;

endmodule

// ===== tow_timer_core.sv
// Purpose: 16-bit counter with overflow flag, interrupt gating and sleep wake-up
// Assumes: Byte register port, read data one cycle after the read strobe
// Notes:   Count writes take precedence over a tick in the same cycle
`include "tow_defs.svh"
`timescale 1ns/100ps

// Functional notes
// - The two count bytes form one 16-bit counter that counts up to FFFFh and wraps to 0000h.
// - Each wrap from FFFFh to 0000h sets the overflow flag in the request register.
// - The overflow interrupt is raised only with counter on, its enable, peripheral and global enables all set.
// - The overflow flag stays set until software clears it, and clearing it drops the request.
// - In sleep the counter runs only in asynchronous counter mode and halts otherwise.
// - In asynchronous mode an external clock or the secondary oscillator advances the counter.
// - An armed overflow during sleep wakes the core to resume after the sleep instruction.
// - After such a wake the core branches to the service routine only if the global enable is set.
// - The secondary oscillator keeps running in sleep whatever the sync bit holds.
// - No peripheral source, bank 3 included, reaches the interrupt without the peripheral enable.
module tow_timer_core #(
  parameter int ADDR_W = `TOW_ADDR_W
) (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // Count sources
  input  wire logic              ext_clk_in,
  input  wire logic              sec_osc_in,
  // Other peripheral requests for bank 3
  input  wire logic [7:0]        bank3_req,
  // Core power handshake
  input  wire logic              sleep_req,
  output logic                   core_sleeping,
  output logic                   wake_pulse,
  output logic                   isr_branch,
  output logic                   sec_osc_run,
  output logic                   irq
);

  // Register state
  logic [15:0]        count_q;
  logic [15:0]        count_d;
  tow_pkg::tow_ctrl_t ctrl_q;
  tow_pkg::tow_glob_t glob_q;
  logic               ovf_flag_q;
  logic               ovf_ie_q;
  logic [7:0]         en3_q;
  logic [7:0]         rdata_q;
  logic               wake_q;
  logic               branch_q;
  tow_pkg::tow_state_t state_q;
  tow_pkg::tow_state_t state_d;

  // Internal nets
  logic tick;
  logic inc;
  logic wrap;
  logic cnt_wr;
  logic sleeping;
  logic periph_pend;
  logic irq_raw;
  logic wake_arm;
  logic ovf_clr;
  logic wake_go;

  // Write strobe decode used by several processes
  function automatic logic wr_hit(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] off,
                                  input logic              wr);
    wr_hit = wr & (a == off);
  endfunction

  assign sleeping = (state_q == tow_pkg::TOW_ST_SLEEP);

  // Count source and sleep qualification
  tow_tick_sel u_tick (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .ctrl       (ctrl_q),
    .sleeping   (sleeping),
    .ext_clk_in (ext_clk_in),
    .sec_osc_in (sec_osc_in),
    .tick       (tick)
  );

  // Enable gating of all requests
  tow_irq_gate u_gate (
    .ovf_flag    (ovf_flag_q),
    .ovf_ie      (ovf_ie_q),
    .ctrl        (ctrl_q),
    .glob        (glob_q),
    .req3        (bank3_req),
    .en3         (en3_q),
    .periph_pend (periph_pend),
    .irq         (irq_raw),
    .wake_arm    (wake_arm)
  );

  // Any count byte write blocks the tick in that cycle
  assign cnt_wr = wr_hit(reg_addr, ADDR_W'(`TOW_OFF_COUNT_LO), reg_wr) |
                  wr_hit(reg_addr, ADDR_W'(`TOW_OFF_COUNT_HI), reg_wr);
  assign inc    = tick & ~cnt_wr;
  assign wrap   = inc & (count_q == `TOW_COUNT_MAX);

  // Next count value
  always_comb begin
    count_d = count_q;
    if (wr_hit(reg_addr, ADDR_W'(`TOW_OFF_COUNT_LO), reg_wr)) begin
      count_d[7:0] = reg_wdata;
    end
    if (wr_hit(reg_addr, ADDR_W'(`TOW_OFF_COUNT_HI), reg_wr)) begin
      count_d[15:8] = reg_wdata;
    end
    if (inc) begin
      count_d = count_q + 16'h0001;
    end
  end

  // Counter register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= `TOW_RST_COUNT;
    end else begin
      count_q <= count_d;
    end
  end

  // Control register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= '0;
    end else if (wr_hit(reg_addr, ADDR_W'(`TOW_OFF_CTRL), reg_wr)) begin
      ctrl_q.on     <= reg_wdata[`TOW_CTRL_ON_BIT];
      ctrl_q.sync   <= reg_wdata[`TOW_CTRL_SYNC_BIT];
      ctrl_q.osc_en <= reg_wdata[`TOW_CTRL_OSC_BIT];
      ctrl_q.cs     <= reg_wdata[`TOW_CTRL_CS_HI:`TOW_CTRL_CS_LO];
    end
  end

  // Global and peripheral enables
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      glob_q <= '0;
    end else if (wr_hit(reg_addr, ADDR_W'(`TOW_OFF_INTERRUPT_CONTROL_REG), reg_wr)) begin
      glob_q.global_irq_enable  <= reg_wdata[`TOW_INTERRUPT_CONTROL_REG_GIE_BIT];
      glob_q.peripheral_irq_enable <= reg_wdata[`TOW_INTERRUPT_CONTROL_REG_PERIPHERAL_IRQ_ENABLE_BIT];
    end
  end

  // Overflow enable, mask of the request register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_ie_q <= 1'b0;
    end else if (wr_hit(reg_addr, ADDR_W'(`TOW_OFF_EN1), reg_wr)) begin
      ovf_ie_q <= reg_wdata[`TOW_EN1_OVF_BIT];
    end
  end

  // Bank 3 enables for neighbouring peripherals
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      en3_q <= `TOW_RST_BYTE;
    end else if (wr_hit(reg_addr, ADDR_W'(`TOW_OFF_EN3), reg_wr)) begin
      en3_q <= reg_wdata;
    end
  end

  // Writing a one to the flag clears it
  assign ovf_clr = wr_hit(reg_addr, ADDR_W'(`TOW_OFF_REQ1), reg_wr) & reg_wdata[`TOW_REQ1_OVF_BIT];

  // Sticky overflow flag, set wins over clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_flag_q <= 1'b0;
    end else if (wrap) begin
      ovf_flag_q <= 1'b1;
    end else if (ovf_clr) begin
      ovf_flag_q <= 1'b0;
    end
  end

  // Wake when an armed overflow happens in sleep
  assign wake_go = sleeping & wrap & wake_arm;

  // Power state transitions
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      tow_pkg::TOW_ST_RUN: begin
        if (sleep_req) begin
          state_d = tow_pkg::TOW_ST_SLEEP;
        end
      end
      tow_pkg::TOW_ST_SLEEP: begin
        if (wake_go) begin
          state_d = tow_pkg::TOW_ST_WAKE;
        end
      end
      tow_pkg::TOW_ST_WAKE: begin
        state_d = tow_pkg::TOW_ST_RUN;
      end
      default: begin
        state_d = tow_pkg::TOW_ST_RUN;
      end
    endcase
  end

  // Power state register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= tow_pkg::TOW_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Wake pulse and service routine decision
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wake_q   <= 1'b0;
      branch_q <= 1'b0;
    end else begin
      wake_q   <= wake_go;
      branch_q <= wake_go & glob_q.global_irq_enable;
    end
  end

  // Register read mux, one cycle latency
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= `TOW_RST_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_W'(`TOW_OFF_COUNT_LO): rdata_q <= count_q[7:0];
        ADDR_W'(`TOW_OFF_COUNT_HI): rdata_q <= count_q[15:8];
        ADDR_W'(`TOW_OFF_CTRL):     rdata_q <= {2'h0, ctrl_q.cs, ctrl_q.osc_en, ctrl_q.sync, 2'h0} |
                                               {7'h00, ctrl_q.on};
        ADDR_W'(`TOW_OFF_REQ1):     rdata_q <= {7'h00, ovf_flag_q};
        ADDR_W'(`TOW_OFF_EN1):      rdata_q <= {7'h00, ovf_ie_q};
        ADDR_W'(`TOW_OFF_INTERRUPT_CONTROL_REG):   rdata_q <= {glob_q.global_irq_enable, glob_q.peripheral_irq_enable, 6'h00};
        ADDR_W'(`TOW_OFF_EN3):      rdata_q <= en3_q;
        ADDR_W'(`TOW_OFF_STATE):    rdata_q <= {4'h0, irq_raw, periph_pend, wake_arm, sleeping};
        default:                    rdata_q <= `TOW_RST_BYTE;
      endcase
    end else begin
      rdata_q <= `TOW_RST_BYTE;
    end
  end

  // Outputs
  assign reg_rdata     = rdata_q;
  assign core_sleeping = sleeping;
  assign wake_pulse    = wake_q;
  assign isr_branch    = branch_q;
  assign sec_osc_run   = ctrl_q.osc_en;
  assign irq           = irq_raw;

endmodule

// ===== tow_core_checker.sv
// Purpose: Port-level assertions for the overflow/wake block
// Assumes: Enable registers are mirrored from writes on the register port
// Notes:   Bound to every tow_timer_core instance
`include "tow_defs.svh"
`timescale 1ns/100ps
module tow_core_checker #(
  parameter int ADDR_W = 3
) (
  input wire logic              mclk,
  input wire logic              arst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic [7:0]        bank3_req,
  input wire logic              core_sleeping,
  input wire logic              wake_pulse,
  input wire logic              isr_branch,
  input wire logic              sec_osc_run,
  input wire logic              irq
);
  logic [7:0] ctrl_q;
  logic [7:0] ie_q;
  logic [7:0] glob_q;
  logic [7:0] en3_q;

  // Mirrors of the enable registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= 8'h00;
      ie_q   <= 8'h00;
      glob_q <= 8'h00;
      en3_q  <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == `TOW_OFF_CTRL) ctrl_q <= reg_wdata;
      if (reg_addr == `TOW_OFF_EN1) ie_q <= reg_wdata;
      if (reg_addr == `TOW_OFF_INTERRUPT_CONTROL_REG) glob_q <= reg_wdata;
      if (reg_addr == `TOW_OFF_EN3) en3_q <= reg_wdata;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_irq_glob; irq |-> glob_q[7:6] == 2'h3; endproperty
  a_irq_glob: assert property (p_irq_glob)
    else $error("irq without both global enables");
  property p_irq_src; irq |-> (ctrl_q[0] && ie_q[0]) || |(bank3_req & en3_q); endproperty
  a_irq_src: assert property (p_irq_src)
    else $error("irq without an enabled source");
  property p_irq_fall; $fell(irq) |-> $past(reg_wr) || $past(bank3_req) != bank3_req; endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq dropped without software action");
  property p_wake_src; wake_pulse |-> $past(core_sleeping) && !core_sleeping; endproperty
  a_wake_src: assert property (p_wake_src)
    else $error("wake pulse not leaving sleep");
  property p_wake_one; wake_pulse |=> !wake_pulse && !isr_branch; endproperty
  a_wake_one: assert property (p_wake_one)
    else $error("wake pulse longer than one cycle");
  // Arming is judged one cycle back, where the wrap was seen
  property p_wake_arm;
    wake_pulse |-> $past(ctrl_q[0]) && $past(ctrl_q[2]) && $past(ie_q[0]) && $past(glob_q[6]);
  endproperty
  a_wake_arm: assert property (p_wake_arm)
    else $error("wake without arming");
  property p_isr; wake_pulse |-> isr_branch == $past(glob_q[7]); endproperty
  a_isr: assert property (p_isr)
    else $error("service branch disagrees with global enable");
  property p_isr_only; isr_branch |-> wake_pulse; endproperty
  a_isr_only: assert property (p_isr_only)
    else $error("service branch outside a wake");
  property p_osc; sec_osc_run == ctrl_q[3]; endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator run differs from its enable");

  c_wake_isr: cover property (wake_pulse && isr_branch);
  c_wake_inl: cover property (wake_pulse && !isr_branch);
  c_irq: cover property (irq);
endmodule

bind tow_timer_core tow_core_checker #(.ADDR_W(ADDR_W)) i_tow_core_checker (
  .mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .bank3_req,
  .core_sleeping, .wake_pulse, .isr_branch, .sec_osc_run, .irq
);

// ===== tow_ext_src.sv
// Purpose: External clock and crystal model feeding the count inputs
// Assumes: Edges are aligned to mclk
// Notes:   Both lines rest low while stopped
`timescale 1ns/100ps
module tow_ext_src (
  input  wire logic       mclk,
  input  wire logic       run,
  input  wire logic [7:0] half,
  output logic            ext_clk,
  output logic            osc
);
  logic [7:0] cnt;

  // Toggle every half cycles, keeps going in sleep
  initial begin
    cnt = 8'h00;
    ext_clk = 1'b0;
    osc = 1'b0;
  end
  always @(posedge mclk) begin
    if (!run) begin
      cnt <= 8'h00;
      ext_clk <= 1'b0;
      osc <= 1'b0;
    end else if (cnt + 8'h01 >= half) begin
      cnt <= 8'h00;
      ext_clk <= ~ext_clk;
      osc <= ~osc;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// ===== tb.sv
// Purpose: Self-checking bench for the overflow/wake block
// Assumes: 10 MHz mclk, inputs driven at rising edges
// Notes:   Register checks in a table, sleep cases by hand
`timescale 1ns/100ps
module tb;
  typedef struct packed {logic [2:0] a; logic [7:0] w; logic [7:0] e;} tow_row_t;
  logic       mclk, arst_n, reg_wr, reg_rd, sleep_req, src_run;
  logic       ext_clk_in, sec_osc_in, core_sleeping, wake_pulse, isr_branch, sec_osc_run, irq, w, b;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, bank3_req, src_half, rv;
  int         failures, total_checks, cyc;
  tow_row_t   rows [6] = '{'{3'h0, 8'h5A, 8'h5A}, '{3'h1, 8'hC3, 8'hC3}, '{3'h2, 8'hFF, 8'h3D},
                           '{3'h4, 8'hFF, 8'h01}, '{3'h5, 8'hFF, 8'hC0}, '{3'h6, 8'hA5, 8'hA5}};

  tow_timer_core i_tow_timer_core (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ext_clk_in, .sec_osc_in, .bank3_req, .sleep_req, .core_sleeping, .wake_pulse, .isr_branch,
    .sec_osc_run, .irq);
  tow_ext_src i_tow_ext_src (.mclk, .run(src_run), .half(src_half), .ext_clk(ext_clk_in), .osc(sec_osc_in));

  // Clock and hang guard
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end

  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkb(string n, logic e, logic g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rc(logic [2:0] a, logic [7:0] e, string n);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    chk(n, e, rv);
    @(posedge mclk);
  endtask
  task automatic nap();
    sleep_req <= 1'b1;
    @(posedge mclk);
    sleep_req <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_wake();
    w = 1'b0;
    for (int i = 0; i < 200 && !w; i++) begin
      @(posedge mclk);
      #1 w = wake_pulse;
      b = isr_branch;
    end
    @(posedge mclk);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, sleep_req, bank3_req, src_run} = '0;
    src_half = 8'h01;
    arst_n = 1'b0;
    {failures, total_checks, cyc} = '0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    // Reset values, then write and read back
    for (int i = 0; i < 8; i++) rc(i[2:0], 8'h00, "reset value");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rc(rows[i].a, rows[i].e, "readback");
      wr(rows[i].a, 8'h00);
    end
    // Wrap on the system clock with no enables
    wr(3'h0, 8'hFD);
    wr(3'h1, 8'hFF);
    wr(3'h2, 8'h01);
    repeat (6) @(posedge mclk);
    wr(3'h2, 8'h00);
    rc(3'h1, 8'h00, "count high");
    rc(3'h3, 8'h01, "overflow flag");
    rc(3'h7, 8'h00, "state no irq");
    // Enable gating and flag clearing
    wr(3'h4, 8'h01);
    wr(3'h5, 8'hC0);
    rc(3'h7, 8'h00, "state timer off");
    wr(3'h2, 8'h11);
    rc(3'h7, 8'h0C, "state irq");
    chkb("irq pin", 1'b1, irq);
    wr(3'h5, 8'h40);
    rc(3'h7, 8'h04, "state no gie");
    chkb("irq pin no gie", 1'b0, irq);
    wr(3'h5, 8'hC0);
    repeat (10) @(posedge mclk);
    rc(3'h3, 8'h01, "flag held");
    wr(3'h3, 8'h01);
    rc(3'h7, 8'h00, "state cleared");
    wr(3'h6, 8'h01);
    bank3_req <= 8'h01;
    rc(3'h7, 8'h0C, "bank3 irq");
    chkb("irq pin bank3", 1'b1, irq);
    wr(3'h5, 8'h80);
    rc(3'h7, 8'h00, "bank3 no peripheral_irq_enable");
    chkb("irq pin no peripheral_irq_enable", 1'b0, irq);
    bank3_req <= 8'h00;
    wr(3'h6, 8'h00);
    // Synchronised counter halts in sleep
    wr(3'h5, 8'h40);
    wr(3'h0, 8'h10);
    wr(3'h2, 8'h19);
    nap();
    src_run <= 1'b1;
    repeat (20) @(posedge mclk);
    rc(3'h0, 8'h10, "count in sleep");
    rc(3'h7, 8'h01, "still asleep");
    chkb("core sleeping", 1'b1, core_sleeping);
    chkb("osc run sync off", 1'b1, sec_osc_run);
    // Armed wake from the external clock, inline resume
    src_run <= 1'b0;
    src_half <= 8'h03;
    wr(3'h0, 8'hFE);
    wr(3'h1, 8'hFF);
    wr(3'h2, 8'h15);
    src_run <= 1'b1;
    wait_wake();
    chkb("wake", 1'b1, w);
    chkb("isr branch", 1'b0, b);
    chkb("core awake", 1'b0, core_sleeping);
    src_run <= 1'b0;
    rc(3'h3, 8'h01, "flag after wake");
    // Armed wake from the crystal, with service branch
    wr(3'h3, 8'h01);
    wr(3'h5, 8'hC0);
    wr(3'h0, 8'hFF);
    wr(3'h1, 8'hFF);
    wr(3'h2, 8'h2D);
    nap();
    src_half <= 8'h01;
    src_run <= 1'b1;
    wait_wake();
    chkb("wake", 1'b1, w);
    chkb("isr branch", 1'b1, b);
    chkb("irq after wrap", 1'b1, irq);
    // Reset in mid-run drops the pending request and the flag
    src_run <= 1'b0;
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    chkb("irq in reset", 1'b0, irq);
    arst_n <= 1'b1;
    @(posedge mclk);
    rc(3'h3, 8'h00, "flag after reset");
    finish_test();
  end
endmodule
